//--- hw/scan_user_macro_pkg.sv
// Constants, cell map and encodings for the boundary scan test logic.
// Assumes one system clock domain; the test clock is sampled as data.
package scan_user_macro_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_IOB = 4;
  localparam int IR_LEN = 3;
  localparam int CELLS_PER_IOB = 3;

  // ----------------------------------------------------------------
  // Boundary register cell positions (bit 0 is nearest the data output)
  // ----------------------------------------------------------------
  localparam int CELL_SPEC_T = 0;
  localparam int CELL_SPEC_O = 1;
  localparam int CELL_IOB_BASE = 2;
  localparam int CELL_OFS_IN = 0;
  localparam int CELL_OFS_OUT = 1;
  localparam int CELL_OFS_OE = 2;
  localparam int CELL_MODE0_IN = CELL_IOB_BASE + CELLS_PER_IOB * NUM_IOB;
  localparam int CELL_MODE2_IN = CELL_MODE0_IN + 1;
  localparam int CELL_MODE1_IN = CELL_MODE0_IN + 2;
  localparam int CELL_MODE1_OUT = CELL_MODE0_IN + 3;
  localparam int CELL_MODE1_OE = CELL_MODE0_IN + 4;
  localparam int CELL_UPDATE = CELL_MODE0_IN + 5;
  localparam int BSR_LEN = CELL_UPDATE + 1;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    INSTR_EXTEST = 3'h0,
    INSTR_SAMPLE = 3'h1,
    INSTR_USER_ONE = 3'h2,
    INSTR_USER_TWO = 3'h3,
    INSTR_READBACK = 3'h4,
    INSTR_CONFIGURE = 3'h5,
    INSTR_RESERVED = 3'h6,
    INSTR_BYPASS = 3'h7
  } instr_t;

  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 3'h1;
  localparam instr_t IR_RESET_VAL = INSTR_BYPASS;

  // ----------------------------------------------------------------
  // TAP controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAPTURE_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4,
    TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6,
    TAP_EXIT2_DR = 4'h7,
    TAP_UPDATE_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAPTURE_IR = 4'ha,
    TAP_SHIFT_IR = 4'hb,
    TAP_EXIT1_IR = 4'hc,
    TAP_PAUSE_IR = 4'hd,
    TAP_EXIT2_IR = 4'he,
    TAP_UPDATE_IR = 4'hf
  } tap_state_t;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic TDO_RESET = 1'h0;
  localparam logic IDLE_RESET = 1'h1;
  localparam logic DRCK_RESET = 1'h1;
  localparam logic PAD_RESET = 1'h0;

endpackage : scan_user_macro_pkg

//--- hw/tap_controller.sv
// Sixteen-state test access port controller.
// Assumes tckRise is a one-cycle pulse per test clock rising edge and
// tms is already synchronised to sys_clk.
`timescale 1ns/100ps
module tap_controller
  import scan_user_macro_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tckRise,
  input wire logic tms,
  input wire logic forceReset,
  output tap_state_t tapState
);

  tap_state_t state_ff;
  tap_state_t nxt_state;

  always_comb begin
    unique case (state_ff)
      TAP_RESET: nxt_state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt_state = tms ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: nxt_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nxt_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nxt_state = tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nxt_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nxt_state = tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR: nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nxt_state = tms ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR: nxt_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nxt_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nxt_state = tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nxt_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nxt_state = tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR: nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  // No separate test reset: five clocks with tms high, forceReset, or the system reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= TAP_RESET;
    end else if (forceReset) begin
      state_ff <= TAP_RESET;
    end else if (tckRise) begin
      state_ff <= nxt_state;
    end
  end

  assign tapState = state_ff;

endmodule : tap_controller

//--- hw/boundary_scan_test_logic.sv
// Boundary scan test logic: TAP, instruction register, boundary, bypass
// and user data paths, pad muxing and user strobes.
// Assumes the test clock, mode select, data in and pad levels are
// asynchronous pins; core and user logic signals are on sys_clk.
//
// Operation
// - Bypass, sample/preload and external test supported
// - Scan option turns pins into dedicated test port
// - No test reset pin; four-pin access only
// - Sixteen-state TAP, instruction decode, data registers
// - Three cells per io block, bonded or not
// - Non io block pins carry direction cells only
// - Program, config clock, done pins have no cells
// - External test Capture-DR loads all cells together
// - Special cells at 0, 1 and last
// - Special cells capture internals, last drives net
// - Bypass is one flop delaying one clock
// - Two user select outputs decode user instructions
// - User scan input shifted out during user instruction
// - Data register clock output for user registers
// - Idle output is NAND of clock and idle
// - Cell order per io block: in, out, enable
// - Mode pins zero, two input; one all three
// - Configure and readback instructions through test port
// - Cells ordered around die from upper right
// - Three-bit instruction codes select data output source
`timescale 1ns/100ps
module boundary_scan_test_logic
  import scan_user_macro_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scanOptionEnabled,
  input wire logic testClockPin,
  input wire logic testModeSelectPin,
  input wire logic testDataInPin,
  output logic testDataOutPin,
  output logic testDataOutPinEn,
  input wire logic [scan_user_macro_pkg::NUM_IOB-1:0] ioPadIn,
  input wire logic [scan_user_macro_pkg::NUM_IOB-1:0] coreOut,
  input wire logic [scan_user_macro_pkg::NUM_IOB-1:0] coreOutEn,
  output logic [scan_user_macro_pkg::NUM_IOB-1:0] ioPadOut,
  output logic [scan_user_macro_pkg::NUM_IOB-1:0] ioPadOutEn,
  input wire logic mode_pin_zero,
  input wire logic mode_pin_two,
  input wire logic coreModeOneOut,
  input wire logic coreModeOneOutEn,
  output logic mode_pin_one,
  output logic mode_pin_one_en,
  input wire logic specialCaptureT,
  input wire logic specialCaptureO,
  output logic special_update_cell_last,
  output logic user_instr_one_selected,
  output logic user_instr_two_selected,
  input wire logic user_scan_out_one,
  input wire logic user_scan_out_two,
  output logic user_data_reg_clock,
  output logic user_idle_strobe,
  input wire logic readbackData,
  input wire logic configDataOut,
  output logic readbackShiftStrobe,
  output logic configShiftStrobe,
  output logic configShiftData
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic isBoundaryInstr(input instr_t ins);
    return (ins == INSTR_EXTEST) || (ins == INSTR_SAMPLE);
  endfunction : isBoundaryInstr

  function automatic logic isUserInstr(input instr_t ins);
    return (ins == INSTR_USER_ONE) || (ins == INSTR_USER_TWO);
  endfunction : isUserInstr

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic tckMeta_ff, tckSync_ff, tckPrev_ff;
  logic tmsMeta_ff, tmsSync_ff;
  logic tdiMeta_ff, tdiSync_ff;
  logic [NUM_IOB-1:0] padMeta_ff, padSync_ff;
  logic [1:0] modeMeta_ff, modeSync_ff;
  logic tckRise, tckFall;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // Resting high avoids a false test clock edge on release
      {tckMeta_ff, tckSync_ff, tckPrev_ff} <= 3'h7;
      {tmsMeta_ff, tmsSync_ff} <= 2'h3;
      {tdiMeta_ff, tdiSync_ff} <= 2'h0;
      {padMeta_ff, padSync_ff} <= '0;
      {modeMeta_ff, modeSync_ff} <= '0;
    end else begin
      {tckPrev_ff, tckSync_ff, tckMeta_ff} <= {tckSync_ff, tckMeta_ff, testClockPin};
      {tmsSync_ff, tmsMeta_ff} <= {tmsMeta_ff, testModeSelectPin};
      {tdiSync_ff, tdiMeta_ff} <= {tdiMeta_ff, testDataInPin};
      {padSync_ff, padMeta_ff} <= {padMeta_ff, ioPadIn};
      {modeSync_ff, modeMeta_ff} <= {modeMeta_ff, mode_pin_two, mode_pin_zero};
    end
  end

  assign tckRise = tckSync_ff & ~tckPrev_ff;
  assign tckFall = ~tckSync_ff & tckPrev_ff;

  // ----------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------
  tap_state_t tapState;

  // Without the scan option the test pins are ordinary user pins
  tap_controller u_tap (
    .sys_clk(sys_clk),
    .rst(rst),
    .tckRise(tckRise),
    .tms(tmsSync_ff),
    .forceReset(~scanOptionEnabled),
    .tapState(tapState)
  );

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [IR_LEN-1:0] irShift_ff;
  instr_t instr_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irShift_ff <= IR_CAPTURE_VAL;
      instr_ff <= IR_RESET_VAL;
    end else if (tapState == TAP_RESET) begin
      instr_ff <= IR_RESET_VAL;
    end else if (tckRise) begin
      unique case (tapState)
        TAP_CAPTURE_IR: irShift_ff <= IR_CAPTURE_VAL;
        TAP_SHIFT_IR: irShift_ff <= {tdiSync_ff, irShift_ff[IR_LEN-1:1]};
        TAP_UPDATE_IR: instr_ff <= instr_t'(irShift_ff);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Boundary register capture vector
  // ----------------------------------------------------------------
  // Program, config clock and done pins are absent from the chain
  logic [BSR_LEN-1:0] captureVec;
  logic [BSR_LEN-1:0] bsrShift_ff, bsrUpdate_ff;

  always_comb begin
    captureVec = '0;
    captureVec[CELL_SPEC_T] = specialCaptureT;
    captureVec[CELL_SPEC_O] = specialCaptureO;
    // Io blocks run from the upper right corner around the die
    for (int k = 0; k < NUM_IOB; k++) begin
      captureVec[CELL_IOB_BASE + CELLS_PER_IOB * k + CELL_OFS_IN] = padSync_ff[k];
      captureVec[CELL_IOB_BASE + CELLS_PER_IOB * k + CELL_OFS_OUT] = coreOut[k];
      captureVec[CELL_IOB_BASE + CELLS_PER_IOB * k + CELL_OFS_OE] = coreOutEn[k];
    end
    captureVec[CELL_MODE0_IN] = modeSync_ff[0];
    captureVec[CELL_MODE2_IN] = modeSync_ff[1];
    captureVec[CELL_MODE1_IN] = mode_pin_one;
    captureVec[CELL_MODE1_OUT] = coreModeOneOut;
    captureVec[CELL_MODE1_OE] = coreModeOneOutEn;
    captureVec[CELL_UPDATE] = bsrUpdate_ff[CELL_UPDATE];
  end

  // ----------------------------------------------------------------
  // Boundary register shift and update stages
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bsrShift_ff <= '0;
    end else if (tckRise && isBoundaryInstr(instr_ff)) begin
      if (tapState == TAP_CAPTURE_DR) begin
        bsrShift_ff <= captureVec;
      end else if (tapState == TAP_SHIFT_DR) begin
        bsrShift_ff <= {tdiSync_ff, bsrShift_ff[BSR_LEN-1:1]};
      end
    end
  end

  // Update stage holds across shifts so pads never ripple
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bsrUpdate_ff <= '0;
    end else if (tckRise && tapState == TAP_UPDATE_DR && isBoundaryInstr(instr_ff)) begin
      bsrUpdate_ff <= bsrShift_ff;
    end
  end

  // ----------------------------------------------------------------
  // Bypass register
  // ----------------------------------------------------------------
  logic bypass_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bypass_ff <= 1'h0;
    end else if (tckRise) begin
      if (tapState == TAP_CAPTURE_DR) begin
        bypass_ff <= 1'h0;
      end else if (tapState == TAP_SHIFT_DR) begin
        bypass_ff <= tdiSync_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Test data output
  // ----------------------------------------------------------------
  logic tdoSource;

  always_comb begin
    tdoSource = bypass_ff;
    if (tapState == TAP_SHIFT_IR) begin
      tdoSource = irShift_ff[0];
    end else begin
      unique case (instr_ff)
        INSTR_EXTEST, INSTR_SAMPLE: tdoSource = bsrShift_ff[0];
        INSTR_USER_ONE: tdoSource = user_scan_out_one;
        INSTR_USER_TWO: tdoSource = user_scan_out_two;
        INSTR_READBACK: tdoSource = readbackData;
        INSTR_CONFIGURE: tdoSource = configDataOut;
        INSTR_RESERVED, INSTR_BYPASS: tdoSource = bypass_ff;
      endcase
    end
  end

  // Falling edge launch gives the next device a full half period of setup
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      testDataOutPin <= TDO_RESET;
      testDataOutPinEn <= 1'h0;
    end else if (!scanOptionEnabled) begin
      testDataOutPinEn <= 1'h0;
    end else if (tckFall) begin
      testDataOutPin <= tdoSource;
      testDataOutPinEn <= (tapState == TAP_SHIFT_IR) || (tapState == TAP_SHIFT_DR);
    end
  end

  // ----------------------------------------------------------------
  // Configuration and readback serial path
  // ----------------------------------------------------------------
  logic drShiftRise;

  assign drShiftRise = tckRise && (tapState == TAP_SHIFT_DR);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      configShiftStrobe <= 1'h0;
      configShiftData <= 1'h0;
      readbackShiftStrobe <= 1'h0;
    end else begin
      configShiftStrobe <= drShiftRise && (instr_ff == INSTR_CONFIGURE);
      readbackShiftStrobe <= drShiftRise && (instr_ff == INSTR_READBACK);
      if (drShiftRise && instr_ff == INSTR_CONFIGURE) begin
        configShiftData <= tdiSync_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------
  logic extestActive, padsDisabled;

  assign extestActive = (instr_ff == INSTR_EXTEST);
  assign padsDisabled = (instr_ff == INSTR_CONFIGURE);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ioPadOut <= '0;
      ioPadOutEn <= '0;
      mode_pin_one <= PAD_RESET;
      mode_pin_one_en <= 1'h0;
      special_update_cell_last <= 1'h0;
    end else begin
      special_update_cell_last <= bsrUpdate_ff[CELL_UPDATE];
      if (padsDisabled) begin
        ioPadOut <= {NUM_IOB{PAD_RESET}};
        ioPadOutEn <= '0;
        mode_pin_one <= PAD_RESET;
        mode_pin_one_en <= 1'h0;
      end else if (extestActive) begin
        for (int k = 0; k < NUM_IOB; k++) begin
          ioPadOut[k] <= bsrUpdate_ff[CELL_IOB_BASE + CELLS_PER_IOB * k + CELL_OFS_OUT];
          ioPadOutEn[k] <= bsrUpdate_ff[CELL_IOB_BASE + CELLS_PER_IOB * k + CELL_OFS_OE];
        end
        mode_pin_one <= bsrUpdate_ff[CELL_MODE1_OUT];
        mode_pin_one_en <= bsrUpdate_ff[CELL_MODE1_OE];
      end else begin
        ioPadOut <= coreOut;
        ioPadOutEn <= coreOutEn;
        mode_pin_one <= coreModeOneOut;
        mode_pin_one_en <= coreModeOneOutEn;
      end
    end
  end

  // ----------------------------------------------------------------
  // User logic strobes
  // ----------------------------------------------------------------
  logic drCaptureOrShift;

  assign drCaptureOrShift = (tapState == TAP_CAPTURE_DR) || (tapState == TAP_SHIFT_DR);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      user_instr_one_selected <= 1'h0;
      user_instr_two_selected <= 1'h0;
      user_data_reg_clock <= DRCK_RESET;
      user_idle_strobe <= IDLE_RESET;
    end else begin
      user_instr_one_selected <= (instr_ff == INSTR_USER_ONE);
      user_instr_two_selected <= (instr_ff == INSTR_USER_TWO);
      // Clock pulses only while a user register captures or shifts
      user_data_reg_clock <= (isUserInstr(instr_ff) && drCaptureOrShift)
                             ? tckSync_ff : DRCK_RESET;
      user_idle_strobe <= ~(tckSync_ff && tapState == TAP_IDLE);
    end
  end

endmodule : boundary_scan_test_logic

//--- test/boundary_scan_test_logic_assertions.sv
// Checker for the boundary scan test logic, bound to its top ports.
// Assumes a bench test clock of 80 ns against a 10 ns sys_clk.
`timescale 1ns/100ps
module boundary_scan_test_logic_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scanOptionEnabled,
  input wire logic testClockPin,
  input wire logic testDataOutPin,
  input wire logic testDataOutPinEn,
  input wire logic user_instr_one_selected,
  input wire logic user_instr_two_selected,
  input wire logic user_data_reg_clock,
  input wire logic user_idle_strobe,
  input wire logic readbackShiftStrobe,
  input wire logic configShiftStrobe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence tckHighRun;
    testClockPin [*4];
  endsequence
  sequence tckLowRun;
    !testClockPin [*4];
  endsequence
  sequence optionOff;
    !scanOptionEnabled [*4];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  reset_values_a: assert property (
    $fell(rst) |-> user_idle_strobe && user_data_reg_clock && !testDataOutPinEn
    && !user_instr_one_selected && !user_instr_two_selected) else $error("reset values");
  option_off_a: assert property (
    optionOff |-> !testDataOutPinEn && !user_instr_one_selected && !user_instr_two_selected)
    else $error("port active with option off");
  sel_exclusive_a: assert property (
    !(user_instr_one_selected && user_instr_two_selected)) else $error("both selects");
  drck_user_a: assert property (
    !user_data_reg_clock |-> user_instr_one_selected || user_instr_two_selected)
    else $error("clock outside user instr");
  drck_high_a: assert property (
    tckHighRun |-> user_data_reg_clock) else $error("clock not following tck");
  idle_high_a: assert property (
    tckLowRun |-> user_idle_strobe) else $error("idle strobe low with tck low");
  tdo_steady_a: assert property (
    tckHighRun |-> $stable(testDataOutPin) && $stable(testDataOutPinEn))
    else $error("output moved in tck high");
  tdo_enable_a: assert property (
    $rose(testDataOutPinEn) |-> !$past(testClockPin, 2)) else $error("enable not on fall");
  strobes_apart_a: assert property (
    !(readbackShiftStrobe && configShiftStrobe)) else $error("both shift strobes");
  cfg_pulse_a: assert property (
    configShiftStrobe |=> !configShiftStrobe) else $error("config strobe too long");
  rb_pulse_a: assert property (
    readbackShiftStrobe |=> !readbackShiftStrobe) else $error("readback strobe too long");
  strobe_rise_a: assert property (
    readbackShiftStrobe || configShiftStrobe |-> $past(testClockPin, 1) && $past(testClockPin, 2))
    else $error("shift strobe without tck rise");
endmodule : boundary_scan_test_logic_checker

bind boundary_scan_test_logic boundary_scan_test_logic_checker
  boundary_scan_test_logic_checker_inst (.*);

//--- test/jtag_tester_model.sv
// Board tester model driving the four-pin test port from sys_clk.
// Assumes the device synchronises its test pins; tck rests high between frames.
`timescale 1ns/100ps
module jtag_tester_model (
  input wire logic sys_clk,
  input wire logic tdoLine,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'h1;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // One 80 ns test clock; TDO is read late in the high phase, as at the rise
  task automatic tckBit(input logic tmsV, input logic tdiV, output logic tdoV);
    @(posedge sys_clk);
    tck <= 1'h0;
    tms <= tmsV;
    tdi <= tdiV;
    repeat (4) @(posedge sys_clk);
    tck <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1 tdoV = tdoLine;
  endtask : tckBit
  // No reset pin: five rises with mode select high, then to Run-Test/Idle
  task automatic tapReset();
    logic d;
    repeat (5) tckBit(1'h1, 1'h0, d);
    tckBit(1'h0, 1'h0, d);
  endtask : tapReset
  // Full scan from Idle back to Idle, LSB first; TDI is left inverted afterwards
  task automatic scan(input logic isIr, input int n, input logic [19:0] din,
                      output logic [19:0] dout);
    logic d;
    dout = '0;
    tckBit(1'h1, 1'h0, d);
    if (isIr) begin
      tckBit(1'h1, 1'h0, d);
    end
    tckBit(1'h0, 1'h0, d);
    tckBit(1'h0, 1'h0, d);
    for (int i = 0; i < n; i++) begin
      tckBit(i == n - 1, din[i], d);
      dout[i] = d;
    end
    tckBit(1'h1, ~din[n-1], d);
    tckBit(1'h0, ~din[n-1], d);
  endtask : scan
endmodule : jtag_tester_model

//--- test/boundary_scan_test_logic_tb_top.sv
// Self-checking bench for the boundary scan test logic.
// Assumes the tester model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module boundary_scan_test_logic_tb_top;
  import scan_user_macro_pkg::*;
  logic sys_clk, rst, scanOptionEnabled, testClockPin, testModeSelectPin, testDataInPin, tdoLine;
  logic testDataOutPin, testDataOutPinEn, mode_pin_zero, mode_pin_two, mode_pin_one;
  logic coreModeOneOut, coreModeOneOutEn, mode_pin_one_en, specialCaptureT, specialCaptureO;
  logic special_update_cell_last, user_instr_one_selected, user_instr_two_selected;
  logic user_scan_out_one, user_scan_out_two, user_data_reg_clock, user_idle_strobe;
  logic readbackData, configDataOut, readbackShiftStrobe, configShiftStrobe, configShiftData;
  logic [NUM_IOB-1:0] ioPadIn, coreOut, coreOutEn, ioPadOut, ioPadOutEn;
  int error_cnt = 0;
  int total_checks = 0;
  int cycleCnt = 0;
  int strobeCnt = 0;
  localparam logic [19:0] PRE = 20'ha5c3b;
  // Released TDO shows the inverse, never a lucky match
  assign tdoLine = testDataOutPinEn ? testDataOutPin : ~testDataOutPin;
  boundary_scan_test_logic boundary_scan_test_logic_inst (.*);
  jtag_tester_model jtag_tester_model_inst (.sys_clk(sys_clk), .tdoLine(tdoLine),
    .tck(testClockPin), .tms(testModeSelectPin), .tdi(testDataInPin));
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (readbackShiftStrobe === 1'h1 || configShiftStrobe === 1'h1) begin
      strobeCnt <= strobeCnt + 1;
    end
    if (cycleCnt == 12000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic loadIr(input logic [2:0] code);
    logic [19:0] d;
    jtag_tester_model_inst.scan(1'h1, IR_LEN, {17'h0, code}, d);
    chk("ir capture", {17'h0, IR_CAPTURE_VAL}, d & 20'h7);
  endtask : loadIr
  task automatic drScan(input string what, input int n, input logic [19:0] din,
                        input logic [19:0] exp, input logic [19:0] mask);
    logic [19:0] d;
    jtag_tester_model_inst.scan(1'h0, n, din, d);
    chk(what, exp & mask, d & mask);
  endtask : drScan
  function automatic logic [19:0] expCells();
    logic [19:0] e;
    e = '0;
    e[CELL_SPEC_T] = specialCaptureT;
    e[CELL_SPEC_O] = specialCaptureO;
    for (int k = 0; k < NUM_IOB; k++) begin
      e[CELL_IOB_BASE + 3 * k + CELL_OFS_IN] = ioPadIn[k];
      e[CELL_IOB_BASE + 3 * k + CELL_OFS_OUT] = coreOut[k];
      e[CELL_IOB_BASE + 3 * k + CELL_OFS_OE] = coreOutEn[k];
    end
    e[CELL_MODE0_IN] = mode_pin_zero;
    e[CELL_MODE2_IN] = mode_pin_two;
    e[CELL_MODE1_OUT] = coreModeOneOut;
    e[CELL_MODE1_OE] = coreModeOneOutEn;
    e[CELL_UPDATE] = PRE[CELL_UPDATE];
    return e;
  endfunction : expCells
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    logic d;
    chk("reset outputs", 20'h0000c, {13'h0, testDataOutPinEn, user_instr_one_selected,
        user_instr_two_selected, user_data_reg_clock, user_idle_strobe, mode_pin_one_en,
        |ioPadOutEn});
    jtag_tester_model_inst.tapReset();
    loadIr(INSTR_SAMPLE);
    @(posedge sys_clk);
    scanOptionEnabled <= 1'h0;
    repeat (8) @(posedge sys_clk);
    scanOptionEnabled <= 1'h1;
    jtag_tester_model_inst.tckBit(1'h0, 1'h0, d);
    drScan("forced bypass", 4, 20'h6, 20'hc, 20'hf);
    $display("test reset finished");
  endtask : testReset
  task automatic testBypass();
    loadIr(INSTR_BYPASS);
    drScan("bypass", 8, 20'ha5, 20'h4a, 20'hff);
    loadIr(INSTR_RESERVED);
    drScan("reserved", 8, 20'h5a, 20'hb4, 20'hff);
    $display("test bypass finished");
  endtask : testBypass
  task automatic testBoundary();
    logic [10:0] ep;
    @(posedge sys_clk);
    ioPadIn <= 4'h5;
    coreOut <= 4'h3;
    coreOutEn <= 4'h9;
    mode_pin_zero <= 1'h1;
    coreModeOneOut <= 1'h1;
    specialCaptureT <= 1'h1;
    loadIr(INSTR_SAMPLE);
    drScan("sample", BSR_LEN, PRE, expCells(),
           ~(20'h1 << CELL_MODE1_IN) & ~(20'h1 << CELL_UPDATE));
    loadIr(INSTR_EXTEST);
    repeat (4) @(posedge sys_clk);
    for (int k = 0; k < NUM_IOB; k++) begin
      ep[k] = PRE[CELL_IOB_BASE + 3 * k + CELL_OFS_OUT];
      ep[4 + k] = PRE[CELL_IOB_BASE + 3 * k + CELL_OFS_OE];
    end
    ep[10:8] = {PRE[CELL_MODE1_OE], PRE[CELL_MODE1_OUT], PRE[CELL_UPDATE]};
    chk("pad drive", {9'h0, ep}, {9'h0, mode_pin_one_en, mode_pin_one,
        special_update_cell_last, ioPadOutEn, ioPadOut});
    drScan("extest", BSR_LEN, PRE, expCells(), ~(20'h1 << CELL_MODE1_IN));
    $display("test boundary finished");
  endtask : testBoundary
  task automatic testUser();
    @(posedge sys_clk);
    user_scan_out_one <= 1'h1;
    user_scan_out_two <= 1'h0;
    for (int i = 0; i < 2; i++) begin
      loadIr(3'(INSTR_USER_ONE + i));
      repeat (2) @(posedge sys_clk);
      chk("user selects", i ? 20'h1 : 20'h2,
          {18'h0, user_instr_one_selected, user_instr_two_selected});
      drScan("user scan", 6, 20'h15, i ? 20'h0 : 20'h3f, 20'h3f);
    end
    $display("test user finished");
  endtask : testUser
  task automatic testConfig();
    int base;
    @(posedge sys_clk);
    readbackData <= 1'h1;
    configDataOut <= 1'h0;
    for (int i = 0; i < 2; i++) begin
      loadIr(3'(INSTR_READBACK + i));
      base = strobeCnt;
      drScan("config scan", 6, 20'h2a, i ? 20'h0 : 20'h3f, 20'h3f);
      chk("shift strobes", 20'd6, 20'(strobeCnt - base));
    end
    chk("pads off", 20'h0, {16'h0, ioPadOutEn});
    chk("config data", 20'h1, {19'h0, configShiftData});
    $display("test config finished");
  endtask : testConfig
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    rst = 1'h1;
    scanOptionEnabled = 1'h1;
    {ioPadIn, coreOut, coreOutEn} = '0;
    {mode_pin_zero, mode_pin_two, coreModeOneOut, coreModeOneOutEn} = '0;
    {specialCaptureT, specialCaptureO, user_scan_out_one, user_scan_out_two} = '0;
    {readbackData, configDataOut} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    testReset();
    testBypass();
    testBoundary();
    testUser();
    testConfig();
    print_verdict();
  end
endmodule : boundary_scan_test_logic_tb_top
